// >>> logic/mlpg_consts.vh
// constants for the mission log password gate
// assumes inclusion by bare name from the design file
`ifndef MLPG_CONSTS_VH
`define MLPG_CONSTS_VH

// register byte addresses on the memory write/read path
`define MLPG_ADDR_RATE_LO      16'h0206
`define MLPG_ADDR_RATE_HI      16'h0207
`define MLPG_ADDR_ALARM_EN     16'h0210
`define MLPG_ADDR_RTC_CTL      16'h0212
`define MLPG_ADDR_MISSION_CTL  16'h0213
`define MLPG_ADDR_PW_CTL       16'h0227
`define MLPG_ADDR_RP_BASE      16'h0228
`define MLPG_ADDR_FP_BASE      16'h0230

// field positions
`define MLPG_BIT_ALARM_LOW     0
`define MLPG_BIT_ALARM_HIGH    1
`define MLPG_BIT_OSC_ENABLE    0
`define MLPG_BIT_HIGH_SPEED    1
`define MLPG_BIT_LOG_ENABLE    0
`define MLPG_BIT_FORMAT_16     2
`define MLPG_BIT_ROLLOVER      4

// reset values and patterns
`define MLPG_PW_CTL_RESET      8'h00
`define MLPG_PW_ENABLE_PATTERN 8'hAA
`define MLPG_RATE_RESET        14'h0001
`define MLPG_CTL_RESET         8'h00

// command kinds presented with a command start
`define MLPG_CMD_READ_CRC      3'h0
`define MLPG_CMD_COPY          3'h1
`define MLPG_CMD_CLEAR         3'h2
`define MLPG_CMD_START         3'h3
`define MLPG_CMD_STOP          3'h4

// timing counts
`define MLPG_PW_LAST_BIT       6'h3F
`define MLPG_SECONDS_PER_MIN   6'h3C

`endif

// >>> logic/mlpg_gate.v
// password gate, mission setup and data-log writer of the temperature logger
// assumes a link front end that decodes commands and password bits, an rtc
// that pulses once per second and a converter that hands in temperatures
`timescale 1ns/1ps
`default_nettype none
`include "mlpg_consts.vh"

module mlpg_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             sys_clk,
	input  wire             reset,
	input  wire             in_valid,
	output reg              in_ready,
	input  wire [WIDTH-1:0] in_data,
	output reg              out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	localparam [AW:0] FULL_CNT = DEPTH;
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	reg [AW:0]      count_reg;
	reg [AW:0]      count_next;
	wire            push;
	wire            pop;
	assign push     = in_valid & in_ready;
	assign pop      = out_valid & out_ready;
	assign out_data = mem[rd_ptr_reg];
	always @* begin
		count_next = count_reg;
		if (push && !pop)
			count_next = count_reg + {{AW{1'b0}}, 1'b1};
		else if (pop && !push)
			count_next = count_reg - {{AW{1'b0}}, 1'b1};
	end
	always @(posedge sys_clk) begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
			in_ready   <= 1'b1;
			out_valid  <= 1'b0;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
			count_reg <= count_next;
			// flags are registered so ready and valid never glitch
			in_ready  <= (count_next != FULL_CNT);
			out_valid <= (count_next != {(AW+1){1'b0}});
		end
	end
endmodule // mlpg_fifo

module mlpg_gate (
	input  wire        sys_clk,
	input  wire        reset,
	input  wire        mem_wr_en,
	input  wire        mem_rd_en,
	input  wire [15:0] mem_addr,
	input  wire [7:0]  mem_wr_data,
	output reg  [7:0]  mem_rd_data,
	input  wire        cmd_start,
	input  wire [2:0]  cmd_kind,
	input  wire        pw_bit_valid,
	input  wire        pw_bit,
	output reg         cmd_grant,
	output reg         cmd_deny,
	input  wire        rtc_sec_tick,
	output reg         sample_req,
	input  wire        temp_valid,
	output wire        temp_ready,
	input  wire [15:0] temp_data,
	output reg         log_wr_en,
	output reg  [12:0] log_wr_addr,
	output reg  [7:0]  log_wr_data,
	output reg         log_full,
	input  wire        alarm_low_evt,
	input  wire        alarm_high_evt,
	output reg         cond_search_match,
	output reg         mission_active,
	output reg         oscillator_enable,
	output reg         logging_enable
);
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_LOW  = 2'h1;
	reg [63:0] read_password_bits_reg;
	reg [63:0] full_password_bits_reg;
	reg [7:0]  password_enable_pattern_reg;
	reg [13:0] sample_rate_reg;
	reg [7:0]  alarm_en_reg;
	reg        high_speed_sample_select_reg;
	reg        format_16_reg;
	reg        rollover_enable_reg;
	reg        alarm_low_flag_reg;
	reg        alarm_high_flag_reg;
	reg        pw_busy_reg;
	reg [5:0]  pw_idx_reg;
	reg        rp_ok_reg;
	reg        fp_ok_reg;
	reg [2:0]  kind_reg;
	reg [5:0]  sec_cnt_reg;
	reg [13:0] interval_cnt_reg;
	reg [1:0]  drain_st_reg;
	reg [12:0] ptr_reg;
	reg [7:0]  low_byte_reg;
	wire        fifo_valid;
	wire [15:0] fifo_data;
	wire        checking_on = (password_enable_pattern_reg == `MLPG_PW_ENABLE_PATTERN);
	wire        rp_ok_now   = rp_ok_reg & (pw_bit == read_password_bits_reg[pw_idx_reg]);
	wire        fp_ok_now   = fp_ok_reg & (pw_bit == full_password_bits_reg[pw_idx_reg]);
	wire        last_bit    = (pw_idx_reg == `MLPG_PW_LAST_BIT);
	wire        decide      = pw_busy_reg & pw_bit_valid & last_bit;
	// full password covers every gated command
	// checking off accepts any 64 bits
	wire        pass_now    = !checking_on | fp_ok_now |
			((kind_reg == `MLPG_CMD_READ_CRC) & rp_ok_now);
	wire        grant_now   = decide & pass_now;
	wire        clear_now   = grant_now & (kind_reg == `MLPG_CMD_CLEAR) & !mission_active;
	// setup and password pages locked in mission
	wire        wr_ok       = mem_wr_en & !mission_active;
	wire        in_rp       = ((mem_addr & 16'hFFF8) == `MLPG_ADDR_RP_BASE);
	wire        in_fp       = ((mem_addr & 16'hFFF8) == `MLPG_ADDR_FP_BASE);
	wire        unit_tick   = rtc_sec_tick &
			(high_speed_sample_select_reg | (sec_cnt_reg == `MLPG_SECONDS_PER_MIN - 6'h01));
	wire [13:0] rate_eff    = (sample_rate_reg == 14'h0000) ? 14'h0001 : sample_rate_reg;
	wire        fifo_ready  = (drain_st_reg == ST_IDLE);
	// step is one or two bytes
	wire [13:0] ptr_sum     = {1'b0, ptr_reg} + (format_16_reg ? 14'h0002 : 14'h0001);
	// passwords and control via memory writes
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			read_password_bits_reg       <= 64'h0000000000000000;
			full_password_bits_reg       <= 64'h0000000000000000;
			password_enable_pattern_reg  <= `MLPG_PW_CTL_RESET;
			sample_rate_reg              <= `MLPG_RATE_RESET;
			alarm_en_reg                 <= `MLPG_CTL_RESET;
			oscillator_enable            <= 1'b0;
			high_speed_sample_select_reg <= 1'b0;
			logging_enable               <= 1'b0;
			format_16_reg                <= 1'b0;
			rollover_enable_reg          <= 1'b0;
		end else if (wr_ok) begin
			// byte lanes, lsb at lowest address
			if (in_rp)
				read_password_bits_reg[mem_addr[2:0]*8 +: 8] <= mem_wr_data;
			if (in_fp)
				full_password_bits_reg[mem_addr[2:0]*8 +: 8] <= mem_wr_data;
			case (mem_addr)
			`MLPG_ADDR_PW_CTL:   password_enable_pattern_reg <= mem_wr_data;
			`MLPG_ADDR_RATE_LO:  sample_rate_reg[7:0] <= mem_wr_data;
			`MLPG_ADDR_RATE_HI:  sample_rate_reg[13:8] <= mem_wr_data[5:0];
			`MLPG_ADDR_ALARM_EN: alarm_en_reg <= mem_wr_data & 8'h03;
			`MLPG_ADDR_RTC_CTL: begin
				oscillator_enable            <= mem_wr_data[`MLPG_BIT_OSC_ENABLE];
				high_speed_sample_select_reg <= mem_wr_data[`MLPG_BIT_HIGH_SPEED];
			end
			`MLPG_ADDR_MISSION_CTL: begin
				logging_enable      <= mem_wr_data[`MLPG_BIT_LOG_ENABLE];
				format_16_reg       <= mem_wr_data[`MLPG_BIT_FORMAT_16];
				rollover_enable_reg <= mem_wr_data[`MLPG_BIT_ROLLOVER];
			end
			default: ;
			endcase
		end
	end
	// reads answer one cycle after the strobe
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			mem_rd_data <= 8'h00;
		end else if (mem_rd_en) begin
			case (mem_addr)
			`MLPG_ADDR_PW_CTL:      mem_rd_data <= password_enable_pattern_reg;
			`MLPG_ADDR_RATE_LO:     mem_rd_data <= sample_rate_reg[7:0];
			`MLPG_ADDR_RATE_HI:     mem_rd_data <= {2'h0, sample_rate_reg[13:8]};
			`MLPG_ADDR_ALARM_EN:    mem_rd_data <= alarm_en_reg;
			`MLPG_ADDR_RTC_CTL: begin
				mem_rd_data <= {6'h00, high_speed_sample_select_reg, oscillator_enable};
			end
			`MLPG_ADDR_MISSION_CTL: mem_rd_data <= {3'h0, rollover_enable_reg, 1'b0, format_16_reg,
					1'b0, logging_enable};
			// password bytes read back as zero
			default:                mem_rd_data <= 8'h00;
			endcase
		end
	end
	// password collection; a new command start restarts it
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pw_busy_reg    <= 1'b0;
			pw_idx_reg     <= 6'h00;
			rp_ok_reg      <= 1'b0;
			fp_ok_reg      <= 1'b0;
			kind_reg       <= `MLPG_CMD_READ_CRC;
			cmd_grant      <= 1'b0;
			cmd_deny       <= 1'b0;
			mission_active <= 1'b0;
		end else begin
			cmd_grant <= grant_now;
			cmd_deny  <= decide & !pass_now;
			if (cmd_start) begin
				pw_busy_reg <= 1'b1;
				pw_idx_reg  <= 6'h00;
				rp_ok_reg   <= 1'b1;
				fp_ok_reg   <= 1'b1;
				kind_reg    <= cmd_kind;
			end else if (pw_busy_reg && pw_bit_valid) begin
				rp_ok_reg  <= rp_ok_now;
				fp_ok_reg  <= fp_ok_now;
				pw_idx_reg <= pw_idx_reg + 6'h01;
				if (last_bit)
					pw_busy_reg <= 1'b0;
			end
			if (grant_now && kind_reg == `MLPG_CMD_START)
				mission_active <= 1'b1;
			if (grant_now && kind_reg == `MLPG_CMD_STOP)
				mission_active <= 1'b0;
		end
	end

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sec_cnt_reg      <= 6'h00;
			interval_cnt_reg <= 14'h0000;
			sample_req       <= 1'b0;
		end else begin
			sample_req <= 1'b0;
			if (!mission_active || !logging_enable) begin
				sec_cnt_reg      <= 6'h00;
				interval_cnt_reg <= 14'h0000;
			end else begin
				if (rtc_sec_tick)
					sec_cnt_reg <= unit_tick ? 6'h00 : sec_cnt_reg + 6'h01;
				if (unit_tick) begin
					if (interval_cnt_reg + 14'h0001 >= rate_eff) begin
						interval_cnt_reg <= 14'h0000;
						sample_req       <= 1'b1;
					end else
						interval_cnt_reg <= interval_cnt_reg + 14'h0001;
				end
			end
		end
	end
	// alarm answer; an event beats a clear in the same cycle
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			alarm_low_flag_reg  <= 1'b0;
			alarm_high_flag_reg <= 1'b0;
			cond_search_match   <= 1'b0;
		end else begin
			alarm_low_flag_reg  <= (alarm_low_flag_reg & !clear_now) | alarm_low_evt;
			alarm_high_flag_reg <= (alarm_high_flag_reg & !clear_now) | alarm_high_evt;
			cond_search_match   <= (alarm_en_reg[`MLPG_BIT_ALARM_LOW] & alarm_low_flag_reg) |
					(alarm_en_reg[`MLPG_BIT_ALARM_HIGH] & alarm_high_flag_reg);
		end
	end
	// buffer soaks up conversions while the log writer is busy
	mlpg_fifo #(
		.WIDTH (16),
		.DEPTH (32),
		.AW    (5)
	) u_fifo (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.in_valid  (temp_valid),
		.in_ready  (temp_ready),
		.in_data   (temp_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready),
		.out_data  (fifo_data)
	);
	// log writer; a full log without rollover still drains so the buffer never jams
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			drain_st_reg <= ST_IDLE;
			ptr_reg      <= 13'h0000;
			low_byte_reg <= 8'h00;
			log_wr_en    <= 1'b0;
			log_wr_addr  <= 13'h0000;
			log_wr_data  <= 8'h00;
			log_full     <= 1'b0;
		end else begin
			log_wr_en <= 1'b0;
			case (drain_st_reg)
			ST_IDLE: begin
				// stop recording when full and no rollover
				if (fifo_valid && !(log_full && !rollover_enable_reg)) begin
					log_wr_en   <= 1'b1;
					log_wr_addr <= ptr_reg;
					log_wr_data <= fifo_data[15:8];
					low_byte_reg <= fifo_data[7:0];
					if (format_16_reg) begin
						drain_st_reg <= ST_LOW;
					end else begin
						ptr_reg <= ptr_sum[12:0];
						if (ptr_sum[13] && !rollover_enable_reg)
							log_full <= 1'b1;
					end
				end
			end
			ST_LOW: begin
				log_wr_en    <= 1'b1;
				log_wr_addr  <= ptr_reg + 13'h0001;
				log_wr_data  <= low_byte_reg;
				ptr_reg      <= ptr_sum[12:0];
				drain_st_reg <= ST_IDLE;
				// rollover restarts at the section start
				if (ptr_sum[13] && !rollover_enable_reg)
					log_full <= 1'b1;
			end
			default: drain_st_reg <= ST_IDLE;
			endcase
			if (clear_now) begin
				ptr_reg  <= 13'h0000;
				log_full <= 1'b0;
			end
		end
	end
endmodule // mlpg_gate
`default_nettype wire

// >>> sim/mlpg_gate_monitor.sv
// checker for the password gate, mission sampling and log writer of mlpg_gate
// bound to mlpg_gate below; sees only its ports, one clock, async reset
`timescale 1ns/1ps
`default_nettype none
module mlpg_gate_monitor (
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic        mem_rd_en,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0]  mem_rd_data,
	input wire logic        cmd_start,
	input wire logic        pw_bit_valid,
	input wire logic        cmd_grant,
	input wire logic        cmd_deny,
	input wire logic        rtc_sec_tick,
	input wire logic        sample_req,
	input wire logic        log_wr_en,
	input wire logic [12:0] log_wr_addr,
	input wire logic        log_full,
	input wire logic        mission_active
);
	default clocking mlpg_cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	logic [6:0]  bits_reg;
	logic [12:0] last_reg;
	logic        seen_reg;
	// 7Fh marks no command since reset; 40h then holds until the next start, so a stray answer before the first command or after a short one misses 64
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			bits_reg <= 7'h7F;
			seen_reg <= 1'b0;
			last_reg <= 13'h0000;
		end else begin
			if (cmd_start)
				bits_reg <= 7'h00;
			else if (pw_bit_valid && bits_reg < 7'h40)
				bits_reg <= bits_reg + 7'h01;
			// a clear moves the pointer, so the step check restarts on any grant
			if (cmd_grant)
				seen_reg <= 1'b0;
			else if (log_wr_en) begin
				seen_reg <= 1'b1;
				last_reg <= log_wr_addr;
			end
		end
	end
	sequence last_bit_s;
		pw_bit_valid && !cmd_start && bits_reg == 7'h3F;
	endsequence
	sequence answer_s;
		cmd_grant || cmd_deny;
	endsequence
	pw_read_zero_a: assert property (
		mem_rd_en && mem_addr >= 16'h0228 && mem_addr <= 16'h0237 |=> mem_rd_data == 8'h00)
		else $error("password byte read not zero");
	answer_timing_a: assert property (
		last_bit_s |=> answer_s)
		else $error("no answer after 64th bit");
	answer_count_a: assert property (
		answer_s |-> bits_reg == 7'h40)
		else $error("answer without 64 bits");
	grant_pulse_a: assert property (
		cmd_grant |=> !cmd_grant && !cmd_deny)
		else $error("grant longer than one cycle");
	sample_mission_a: assert property (
		sample_req |-> mission_active)
		else $error("sample outside mission");
	sample_tick_a: assert property (
		sample_req |-> $past(rtc_sec_tick))
		else $error("sample not after tick");
	log_step_a: assert property (
		log_wr_en && seen_reg |-> log_wr_addr == last_reg + 13'h0001)
		else $error("log pointer step wrong");
	full_stop_a: assert property (
		log_full && $past(log_full) |-> !log_wr_en)
		else $error("log write while full");
	start_gated_a: assert property (
		$rose(mission_active) |-> cmd_grant)
		else $error("mission started without grant");
	stop_gated_a: assert property (
		$fell(mission_active) |-> cmd_grant)
		else $error("mission stopped without grant");
endmodule // mlpg_gate_monitor
bind mlpg_gate mlpg_gate_monitor mlpg_gate_monitor_i (
	.sys_clk, .reset, .mem_rd_en, .mem_addr, .mem_rd_data, .cmd_start, .pw_bit_valid,
	.cmd_grant, .cmd_deny, .rtc_sec_tick, .sample_req, .log_wr_en, .log_wr_addr,
	.log_full, .mission_active
);
`default_nettype wire

// >>> sim/mlpg_host.sv
// host model: memory writes and reads, commands with their 64 password bits
// assumes the bench calls its tasks one at a time, just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module mlpg_host (
	input wire logic        sys_clk,
	input wire logic [7:0]  mem_rd_data,
	input wire logic        cmd_grant,
	input wire logic        cmd_deny,
	output var logic        mem_wr_en,
	output var logic        mem_rd_en,
	output var logic [15:0] mem_addr,
	output var logic [7:0]  mem_wr_data,
	output var logic        cmd_start,
	output var logic [2:0]  cmd_kind,
	output var logic        pw_bit_valid,
	output var logic        pw_bit
);
	initial begin
		{mem_wr_en, mem_rd_en, cmd_start, pw_bit_valid, pw_bit} = 5'h00;
		mem_addr = 16'h0000;
		mem_wr_data = 8'h00;
		cmd_kind = 3'h0;
	end
	// passwords go through the ordinary write path
	task wr(input logic [15:0] a, input logic [7:0] dt);
		@(posedge sys_clk); #1;
		mem_wr_en = 1'b1;
		mem_addr = a;
		mem_wr_data = dt;
		@(posedge sys_clk); #1;
		mem_wr_en = 1'b0;
		mem_wr_data = ~dt;
	endtask
	task rd(input logic [15:0] a, output logic [7:0] dt);
		@(posedge sys_clk); #1;
		mem_rd_en = 1'b1;
		mem_addr = a;
		@(posedge sys_clk); #1;
		mem_rd_en = 1'b0;
		dt = mem_rd_data;
	endtask
	// n below 64 only for no-answer cases; answer polled for three cycles
	task cmd(input logic [2:0] k, input logic [63:0] pw, input int n,
		output logic g, output logic d);
		int i;
		g = 1'b0;
		d = 1'b0;
		@(posedge sys_clk); #1;
		cmd_start = 1'b1;
		cmd_kind = k;
		@(posedge sys_clk); #1;
		cmd_start = 1'b0;
		// bit 0 first, right after the command
		for (i = 0; i < n; i++) begin
			pw_bit_valid = 1'b1;
			pw_bit = pw[i];
			@(posedge sys_clk); #1;
		end
		pw_bit_valid = 1'b0;
		pw_bit = ~pw_bit;
		for (i = 0; i < 3; i++) begin
			g = g | (cmd_grant === 1'b1);
			d = d | (cmd_deny === 1'b1);
			@(posedge sys_clk); #1;
		end
	endtask
endmodule // mlpg_host
`default_nettype wire

// >>> sim/mlpg_gate_tb.sv
// self-checking bench for mlpg_gate with a host model and a log reference model
// assumes mlpg_consts.vh on the include path; no parameters to shrink
`timescale 1ns/1ps
`default_nettype none
`include "mlpg_consts.vh"
module mlpg_gate_tb;
	logic sys_clk = 0, reset = 1, rtc_sec_tick = 0, temp_valid = 0;
	logic alarm_low_evt = 0, alarm_high_evt = 0;
	logic [15:0] temp_data = 16'h0000;
	wire logic mem_wr_en, mem_rd_en, cmd_start, pw_bit_valid, pw_bit, cmd_grant, cmd_deny;
	wire logic sample_req, temp_ready, log_wr_en, log_full, cond_search_match;
	wire logic mission_active, oscillator_enable, logging_enable;
	wire logic [15:0] mem_addr;
	wire logic [7:0] mem_wr_data, mem_rd_data, log_wr_data;
	wire logic [2:0] cmd_kind;
	wire logic [12:0] log_wr_addr;
	int errors = 0, checks_done = 0, cyc = 0, ptr = 0, sreq = 0, s0, refused = 0, i;
	logic fmt16 = 0, roll = 0, full_m = 0, g, d;
	logic [7:0] b;
	logic [63:0] rpw, fpw;
	logic [20:0] exp_q[$];
	always #12.5 sys_clk = ~sys_clk;
	mlpg_gate mlpg_gate_i (.sys_clk, .reset, .mem_wr_en, .mem_rd_en, .mem_addr,
		.mem_wr_data, .mem_rd_data, .cmd_start, .cmd_kind, .pw_bit_valid, .pw_bit,
		.cmd_grant, .cmd_deny, .rtc_sec_tick, .sample_req, .temp_valid, .temp_ready,
		.temp_data, .log_wr_en, .log_wr_addr, .log_wr_data, .log_full, .alarm_low_evt,
		.alarm_high_evt, .cond_search_match, .mission_active, .oscillator_enable,
		.logging_enable);
	mlpg_host mlpg_host_i (.sys_clk, .mem_rd_data, .cmd_grant, .cmd_deny, .mem_wr_en,
		.mem_rd_en, .mem_addr, .mem_wr_data, .cmd_start, .cmd_kind, .pw_bit_valid, .pw_bit);
	task end_sim;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task cmd(input logic [2:0] k, input logic [63:0] pw, input logic eg, input logic ed);
		mlpg_host_i.cmd(k, pw, 64, g, d);
		chk("cmd_grant", {15'h0000, eg}, {15'h0000, g});
		chk("cmd_deny", {15'h0000, ed}, {15'h0000, d});
	endtask
	task tick;
		rtc_sec_tick = 1;
		@(posedge sys_clk); #1;
		rtc_sec_tick = 0;
		@(posedge sys_clk); #1;
	endtask
	// reference log writer: 16-bit entries high byte first, full stops unless rollover
	task push(input logic [15:0] t);
		if (!full_m) begin
			exp_q.push_back({13'(ptr), t[15:8]});
			if (fmt16)
				exp_q.push_back({13'(ptr + 1), t[7:0]});
			ptr = (ptr + (fmt16 ? 2 : 1)) % 8192;
			full_m = (ptr == 0) && !roll;
		end
	endtask
	// data held until taken; a low ready counts as one refusal
	task feed(input int n);
		int k;
		logic tk;
		k = 0;
		temp_data = 16'($urandom);
		while (k < n) begin
			temp_valid = 1;
			tk = (temp_ready === 1'b1);
			if (tk) begin
				push(temp_data);
				k++;
			end else
				refused++;
			@(posedge sys_clk); #1;
			if (tk)
				temp_data = 16'($urandom);
		end
		temp_valid = 0;
		repeat (60) @(posedge sys_clk);
		#1;
	endtask
	always @(negedge sys_clk) begin
		if (sample_req === 1'b1)
			sreq++;
		if (log_wr_en === 1'b1) begin
			if (exp_q.size() == 0)
				chk("log extra write", 16'h0000, 16'h0001);
			else begin
				chk("log_wr_addr", {3'h0, exp_q[0][20:8]}, {3'h0, log_wr_addr});
				chk("log_wr_data", {8'h00, exp_q[0][7:0]}, {8'h00, log_wr_data});
				void'(exp_q.pop_front());
			end
		end
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 70000) begin
			errors++;
			end_sim;
		end
	end
	initial begin
		void'($urandom(19839));
		rpw = {$urandom, $urandom};
		fpw = {$urandom, $urandom};
		repeat (6) @(posedge sys_clk);
		#1;
		chk("temp_ready in reset", 16'h0001, {15'h0000, temp_ready});
		reset = 0;
		for (i = 0; i < 8; i++) begin
			mlpg_host_i.wr(16'(`MLPG_ADDR_RP_BASE + i), rpw[8*i+:8]);
			mlpg_host_i.wr(16'(`MLPG_ADDR_FP_BASE + i), fpw[8*i+:8]);
		end
		for (i = 0; i < 17; i++) begin
			mlpg_host_i.rd(i < 16 ? 16'(`MLPG_ADDR_RP_BASE + i) : 16'h0400, b);
			chk("password read", 16'h0000, {8'h00, b});
		end
		for (i = 0; i < 5; i++)
			if (i != 3)
				cmd(3'(i), {$urandom, $urandom}, 1, 0);
		mlpg_host_i.cmd(`MLPG_CMD_READ_CRC, rpw, 63, g, d);
		chk("short password answer", 16'h0000, {14'h0000, g, d});
		mlpg_host_i.wr(`MLPG_ADDR_PW_CTL, 8'hAB);
		cmd(`MLPG_CMD_COPY, ~fpw, 1, 0);
		mlpg_host_i.wr(`MLPG_ADDR_PW_CTL, `MLPG_PW_ENABLE_PATTERN);
		for (i = 0; i < 5; i++)
			cmd(3'(i), ~fpw, 0, 1);
		for (i = 0; i < 5; i++)
			if (i != 3)
				cmd(3'(i), fpw, 1, 0);
		cmd(`MLPG_CMD_READ_CRC, rpw, 1, 0);
		cmd(`MLPG_CMD_COPY, rpw, 0, 1);
		mlpg_host_i.wr(`MLPG_ADDR_ALARM_EN, 8'h02);
		alarm_low_evt = 1;
		@(posedge sys_clk); #1;
		alarm_low_evt = 0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("cond_search_match", 16'h0000, {15'h0000, cond_search_match});
		alarm_high_evt = 1;
		@(posedge sys_clk); #1;
		alarm_high_evt = 0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("cond_search_match", 16'h0001, {15'h0000, cond_search_match});
		cmd(`MLPG_CMD_CLEAR, fpw, 1, 0);
		chk("cond_search_match", 16'h0000, {15'h0000, cond_search_match});
		mlpg_host_i.wr(`MLPG_ADDR_RTC_CTL, 8'h03);
		mlpg_host_i.wr(`MLPG_ADDR_MISSION_CTL, 8'h05);
		mlpg_host_i.wr(`MLPG_ADDR_RATE_LO, 8'h02);
		mlpg_host_i.wr(`MLPG_ADDR_RATE_HI, 8'h00);
		mlpg_host_i.rd(`MLPG_ADDR_MISSION_CTL, b);
		chk("mission control", 16'h0005, {8'h00, b});
		mlpg_host_i.rd(`MLPG_ADDR_RATE_LO, b);
		chk("sample rate", 16'h0002, {8'h00, b});
		chk("enables", 16'h0003, {14'h0000, oscillator_enable, logging_enable});
		fmt16 = 1;
		cmd(`MLPG_CMD_START, fpw, 1, 0);
		chk("mission_active", 16'h0001, {15'h0000, mission_active});
		mlpg_host_i.wr(`MLPG_ADDR_PW_CTL, 8'h00);
		cmd(`MLPG_CMD_COPY, ~fpw, 0, 1);
		s0 = sreq;
		repeat (8) tick;
		chk("samples at rate 2 s", 16'h0004, 16'(sreq - s0));
		feed(4100);
		chk("fifo refused", 16'h0001, {15'h0000, refused > 0});
		chk("log left", 16'h0000, 16'(exp_q.size()));
		chk("log_full", 16'h0001, {15'h0000, log_full});
		cmd(`MLPG_CMD_STOP, fpw, 1, 0);
		chk("mission_active", 16'h0000, {15'h0000, mission_active});
		mlpg_host_i.wr(`MLPG_ADDR_RTC_CTL, 8'h01);
		mlpg_host_i.wr(`MLPG_ADDR_MISSION_CTL, 8'h11);
		mlpg_host_i.wr(`MLPG_ADDR_RATE_LO, 8'h01);
		cmd(`MLPG_CMD_CLEAR, fpw, 1, 0);
		{fmt16, roll, full_m, ptr} = {1'b0, 1'b1, 1'b0, 32'h0000_0000};
		cmd(`MLPG_CMD_START, fpw, 1, 0);
		s0 = sreq;
		repeat (120) tick;
		chk("samples at rate 1 min", 16'h0002, 16'(sreq - s0));
		feed(8200);
		chk("log left", 16'h0000, 16'(exp_q.size()));
		chk("log_full", 16'h0000, {15'h0000, log_full});
		end_sim;
	end
endmodule // mlpg_gate_tb
`default_nettype wire
